// ==== asr_line_model.sv ====
// far-end serial transmitter driving the receive line
`default_nettype none
module asr_line_model #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic aclk,
  output var  logic line
);
  timeunit 1ns;
  timeprecision 1ns;
  int bit_clks = BIT_CLKS;
  initial line = 1'b1;
  // one frame: low start, data lsb first, chosen stop level, then idle high
  task automatic send(input logic [8:0] d, input logic nine, input logic stop);
    logic [10:0] f;
    int          nb;
    nb = nine ? 11 : 10;
    f = nine ? {stop, d, 1'b0} : {1'b1, stop, d[7:0], 1'b0};
    for (int i = 0; i < nb; i++)
    begin
      @(posedge aclk);
      line <= f[i];
      repeat (bit_clks - 1) @(posedge aclk);
    end
    @(posedge aclk);
    line <= 1'b1;
    repeat (2 * bit_clks) @(posedge aclk);
  endtask
endmodule // asr_line_model
`default_nettype wire

// ==== asr_receiver.v ====
// asynchronous serial receiver with address detect and axi4-lite registers
// Behaviour
// R1: software programs divisor low/high, high speed and wide divisor bits first
// R2: port runs only with serial port enable set and clocked mode clear
// R3: software sets the receive pin as digital input
// R4: ninth bit receive enable selects 9-bit characters, else 8-bit
// R5: characters are accepted only while continuous receive enable is set
// R6: receive flag sets when a character moves into the receive buffer
// R7: receive interrupt raised only when receive interrupt enable is set
// R8: status read returns error flags and ninth data bit
// R9: buffer read returns the low eight data bits
// R10: clearing continuous receive enable clears the overrun flag
// R11: software enables 9-bit reception before address detect mode
// R12: address detect enable switches receiver into address detect mode
// R13: in address detect mode only ninth-bit-set characters are buffered
// R14: in address detect mode reported ninth bit always reads one
// R15: software, not hardware, compares the address
// R16: with address detect cleared every character is buffered and flagged
// R17: low start, high stop, lsb first; low stop gives framing error
// R18: overrun when buffer full at completion; transfers stop until cleared
`default_nettype none
`include "asr_regs.vh"
module asr_receiver (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        rx_pin,
  output wire        irq
);
  // -------------------------------------------------------------
  // registers
  // -------------------------------------------------------------
  reg  [7:0]  ctrl_reg;
  reg  [7:0]  div_low_reg;
  reg  [7:0]  div_high_reg;
  reg  [2:0]  irq_stat_reg;
  reg  [2:0]  irq_en_reg;
  reg  [8:0]  buf_reg;
  reg         full_reg;
  reg         ferr_reg;
  reg         overrun_error_flag_reg;
  reg         rx_meta_reg;
  reg         rx_sync_reg;
  reg  [15:0] div_cnt_reg;
  reg         tick_reg;
  reg  [7:0]  aw_addr_reg;
  reg         aw_have_reg;
  reg  [31:0] w_data_reg;
  reg         w_have_reg;
  reg         w_lane_reg;
  wire        port_on;
  wire        rx_on;
  wire        core_done;
  wire [8:0]  core_data;
  wire        core_ferr;
  wire        accept;
  wire        overrun;
  wire        do_write;
  wire        do_read;
  wire        buf_read;
  wire [15:0] div_full;
  wire [15:0] div_eff;
  wire [2:0]  irq_clr;
  wire        load;
  wire [7:0]  ctrl_wr;
  wire [7:0]  en_merge;
  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  function [7:0] lane_merge;
    input [7:0] old;
    input [7:0] val;
    input       en;
    begin
      lane_merge = en ? val : old;
    end
  endfunction
  function sticky_next;
    input ev;
    input cur;
    input clr;
    begin
      sticky_next = ev || (cur && !clr);
    end
  endfunction
  // -------------------------------------------------------------
  // enables and rate
  // -------------------------------------------------------------
  assign port_on = ctrl_reg[`ASR_CTRL_SERIAL_PORT_ENABLE] && !ctrl_reg[`ASR_CTRL_SYNC]; // R2
  assign rx_on   = port_on && ctrl_reg[`ASR_CTRL_CONTINUOUS_RECEIVE_ENABLE]; // R5
  // wide: 16-bit divisor, else low byte only; slow mode keeps divisor bits 13:0 and samples 4x slower
  assign div_full = ctrl_reg[`ASR_CTRL_WIDE] ? {div_high_reg, div_low_reg}
                                             : {8'h00, div_low_reg};
  assign div_eff  = ctrl_reg[`ASR_CTRL_HIGH_SPEED_RATE_SELECT] ? div_full : {div_full[13:0], 2'b11};
  always @(posedge aclk)
  begin
    if (!aresetn || !port_on)
    begin
      div_cnt_reg <= 16'h0000;
      tick_reg    <= 1'b0;
    end
    else if (div_cnt_reg >= div_eff)
    begin
      div_cnt_reg <= 16'h0000;
      tick_reg    <= 1'b1;
    end
    else
    begin
      div_cnt_reg <= div_cnt_reg + 16'h0001;
      tick_reg    <= 1'b0;
    end
  end
  // -------------------------------------------------------------
  // pin synchroniser and frame receiver
  // -------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
    end
    else
    begin
      rx_meta_reg <= rx_pin;
      rx_sync_reg <= rx_meta_reg;
    end
  end
  asr_rx_core u_core (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .tick      (tick_reg),
    .enable    (rx_on),
    .nine      (ctrl_reg[`ASR_CTRL_NINTH]),
    .rx_sync   (rx_sync_reg),
    .done      (core_done),
    .data      (core_data),
    .frame_err (core_ferr)
  );
  // -------------------------------------------------------------
  // receive buffer
  // -------------------------------------------------------------
  // address filter: only ninth-bit-set characters pass while enabled
  assign accept  = core_done && !overrun_error_flag_reg &&
                   (!ctrl_reg[`ASR_CTRL_ADDRESS_DETECT_ENABLE] || core_data[8]); // R12 R13 R16
  // overrun: buffer still full and not read in this same cycle
  assign overrun = accept && full_reg && !buf_read; // R18
  assign load    = accept && !overrun;
  assign do_read  = s_axi_arvalid && !s_axi_rvalid;
  assign buf_read = do_read && (s_axi_araddr == `ASR_OFF_BUFFER);
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      buf_reg  <= 9'h000;
      full_reg <= 1'b0;
      ferr_reg <= 1'b0;
      overrun_error_flag_reg <= 1'b0;
    end
    else
    begin
      if (!rx_on)
        overrun_error_flag_reg <= 1'b0; // R10
      else if (overrun)
        overrun_error_flag_reg <= 1'b1; // R18
      if (load)
      begin
        buf_reg  <= core_data; // R6
        ferr_reg <= core_ferr;
        full_reg <= 1'b1; // R6
      end
      else if (buf_read)
        full_reg <= 1'b0;
    end
  end
  // -------------------------------------------------------------
  // interrupts
  // -------------------------------------------------------------
  assign irq_clr = (do_write && aw_addr_reg == `ASR_OFF_IRQ_CLR) ?
                   (w_data_reg[2:0] & {3{w_lane_reg}}) : 3'b000;
  // an event in the same cycle as its clear wins
  always @(posedge aclk)
  begin
    if (!aresetn)
      irq_stat_reg <= 3'b000;
    else
    begin
      irq_stat_reg[`ASR_IRQ_RECV] <= sticky_next(load, irq_stat_reg[`ASR_IRQ_RECV],
                                                 irq_clr[0]); // R6
      irq_stat_reg[`ASR_IRQ_FERR] <= sticky_next(load && core_ferr, irq_stat_reg[`ASR_IRQ_FERR],
                                                 irq_clr[1]);
      irq_stat_reg[`ASR_IRQ_OVERRUN_ERROR_FLAG] <= sticky_next(overrun, irq_stat_reg[`ASR_IRQ_OVERRUN_ERROR_FLAG],
                                                 irq_clr[2]); // R18
    end
  end
  assign irq = |(irq_stat_reg & irq_en_reg); // R7
  // -------------------------------------------------------------
  // axi4-lite write channel
  // -------------------------------------------------------------
  assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_reg && !s_axi_bvalid;
  assign do_write      = aw_have_reg && w_have_reg;
  assign ctrl_wr       = lane_merge(ctrl_reg, {1'b0, w_data_reg[6:0]}, w_lane_reg);
  assign en_merge      = lane_merge({5'h00, irq_en_reg}, w_data_reg[7:0], w_lane_reg);
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_reg  <= 1'b0;
      w_have_reg   <= 1'b0;
      aw_addr_reg  <= 8'h00;
      w_data_reg   <= 32'h00000000;
      w_lane_reg   <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
      ctrl_reg     <= `ASR_CTRL_RESET;
      div_low_reg  <= `ASR_DIV_RESET;
      div_high_reg <= `ASR_DIV_RESET;
      irq_en_reg   <= 3'b000;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr_reg <= s_axi_awaddr;
        aw_have_reg <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data_reg <= s_axi_wdata;
        w_lane_reg <= s_axi_wstrb[0];
        w_have_reg <= 1'b1;
      end
      if (do_write)
      begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'b00;
        case (aw_addr_reg)
          `ASR_OFF_CTRL:     ctrl_reg     <= ctrl_wr;
          `ASR_OFF_DIV_LOW:  div_low_reg  <= lane_merge(div_low_reg, w_data_reg[7:0],
                                                        w_lane_reg);
          `ASR_OFF_DIV_HIGH: div_high_reg <= lane_merge(div_high_reg, w_data_reg[7:0],
                                                        w_lane_reg);
          `ASR_OFF_IRQ_EN:   irq_en_reg   <= en_merge[2:0];
          `ASR_OFF_IRQ_CLR:  irq_en_reg   <= irq_en_reg;
          `ASR_OFF_STATUS, `ASR_OFF_BUFFER, `ASR_OFF_IRQ_STAT:
            irq_en_reg <= irq_en_reg;
          default:           s_axi_bresp  <= 2'b10;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  // -------------------------------------------------------------
  // axi4-lite read channel
  // -------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'b00;
    end
    else if (do_read)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'b00;
      case (s_axi_araddr)
        `ASR_OFF_CTRL:     s_axi_rdata <= {24'h000000, ctrl_reg};
        `ASR_OFF_STATUS:   s_axi_rdata <= {28'h0000000, full_reg, overrun_error_flag_reg, ferr_reg,
                                          ctrl_reg[`ASR_CTRL_NINTH] & buf_reg[8]}; // R8 R14
        `ASR_OFF_BUFFER:   s_axi_rdata <= {24'h000000, buf_reg[7:0]}; // R9
        `ASR_OFF_DIV_LOW:  s_axi_rdata <= {24'h000000, div_low_reg};
        `ASR_OFF_DIV_HIGH: s_axi_rdata <= {24'h000000, div_high_reg};
        `ASR_OFF_IRQ_STAT: s_axi_rdata <= {29'h0, irq_stat_reg};
        `ASR_OFF_IRQ_EN:   s_axi_rdata <= {29'h0, irq_en_reg};
        `ASR_OFF_IRQ_CLR:  s_axi_rdata <= 32'h00000000;
        default:
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule // asr_receiver
`default_nettype wire

// ==== asr_receiver_props.sv ====
// port assertions for the serial receiver
`default_nettype none
module asr_receiver_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_read_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  a_bad_read: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("unmapped read data not zero");
  a_resp_legal: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
    else $error("illegal write response");
  a_irq_reset: assert property ($rose(aresetn) |-> !irq)
    else $error("interrupt high after reset");
  a_irq_sticky: assert property (irq && !s_axi_awvalid && !$past(s_axi_awvalid) |=> irq)
    else $error("interrupt dropped without a write");
endmodule // asr_receiver_props
bind asr_receiver asr_receiver_props i_asr_receiver_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .irq(irq)
);
`default_nettype wire

// ==== asr_regs.vh ====
// register map, field positions and reset values of the serial receiver
`ifndef ASR_REGS_VH
`define ASR_REGS_VH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define ASR_OFF_CTRL      8'h00
`define ASR_OFF_STATUS    8'h04
`define ASR_OFF_BUFFER    8'h08
`define ASR_OFF_DIV_LOW   8'h0c
`define ASR_OFF_DIV_HIGH  8'h10
`define ASR_OFF_IRQ_STAT  8'h14
`define ASR_OFF_IRQ_EN    8'h18
`define ASR_OFF_IRQ_CLR   8'h1c
// ---------------------------------------------------------------
// control fields
// ---------------------------------------------------------------
`define ASR_CTRL_SERIAL_PORT_ENABLE     0
`define ASR_CTRL_SYNC     1
`define ASR_CTRL_NINTH    2
`define ASR_CTRL_CONTINUOUS_RECEIVE_ENABLE     3
`define ASR_CTRL_ADDRESS_DETECT_ENABLE    4
`define ASR_CTRL_HIGH_SPEED_RATE_SELECT     5
`define ASR_CTRL_WIDE     6
`define ASR_CTRL_RESET    8'h00
// ---------------------------------------------------------------
// status fields
// ---------------------------------------------------------------
`define ASR_ST_RX9D       0
`define ASR_ST_FERR       1
`define ASR_ST_OVERRUN_ERROR_FLAG       2
`define ASR_ST_FULL       3
// ---------------------------------------------------------------
// interrupt status fields
// ---------------------------------------------------------------
`define ASR_IRQ_RECV      0
`define ASR_IRQ_FERR      1
`define ASR_IRQ_OVERRUN_ERROR_FLAG      2
`define ASR_DIV_RESET     8'h00
`define ASR_OVERSAMPLE    5'd16
`endif

// ==== asr_rx_core.v ====
// serial frame receiver: start detect, sampling, shift register
`default_nettype none
module asr_rx_core (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        tick,
  input  wire        enable,
  input  wire        nine,
  input  wire        rx_sync,
  output reg         done,
  output reg  [8:0]  data,
  output reg         frame_err
);
  // -------------------------------------------------------------
  // state machine
  // -------------------------------------------------------------
  localparam [3:0] S_IDLE  = 4'b0001;
  localparam [3:0] S_START = 4'b0010;
  localparam [3:0] S_DATA  = 4'b0100;
  localparam [3:0] S_STOP  = 4'b1000;
  reg [3:0] state_reg;
  reg [3:0] os_reg;
  reg [3:0] bit_reg;
  reg [8:0] shift_reg;
  wire      mid;
  wire      last_bit;
  assign mid      = (os_reg == 4'h7) && tick;
  assign last_bit = nine ? (bit_reg == 4'd8) : (bit_reg == 4'd7);
  always @(posedge aclk)
  begin
    done <= 1'b0;
    if (!aresetn || !enable)
    begin
      state_reg <= S_IDLE;
      os_reg    <= 4'h0;
      bit_reg   <= 4'h0;
      shift_reg <= 9'h000;
      data      <= 9'h000;
      frame_err <= 1'b0;
    end
    else
    begin
      if (tick)
        os_reg <= os_reg + 4'h1;
      case (state_reg)
        S_IDLE:
          if (!rx_sync)
          begin
            state_reg <= S_START;
            os_reg    <= 4'h0;
          end
        S_START:
          if (mid)
          begin
            os_reg  <= 4'h8;
            bit_reg <= 4'h0;
            state_reg <= rx_sync ? S_IDLE : S_DATA;
          end
        S_DATA:
          if (mid)
          begin
            // lsb first R17
            shift_reg <= {rx_sync, shift_reg[8:1]};
            bit_reg   <= bit_reg + 4'h1;
            if (last_bit)
              state_reg <= S_STOP;
          end
        S_STOP:
          if (mid)
          begin
            data      <= nine ? shift_reg : {1'b0, shift_reg[8:1]}; // R4
            frame_err <= !rx_sync; // R17
            done      <= 1'b1;
            state_reg <= S_IDLE;
          end
        default:
          state_reg <= S_IDLE;
      endcase
    end
  end
endmodule // asr_rx_core
`default_nettype wire

// ==== test_asr_receiver.sv ====
// self-checking bench of the serial receiver
`default_nettype none
module test_asr_receiver;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  wire logic   awready, wready, bvalid, arready, rvalid, irq, rx_line;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  int          bad_count = 0;
  int          n_compared = 0;
  logic [31:0] v;
  logic [1:0]  r;
  always #25 aclk = ~aclk;
  asr_line_model i_asr_line_model (.aclk(aclk), .line(rx_line));
  asr_receiver i_asr_receiver (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_pin(rx_line), .irq(irq)
  );
  // ----------------------------
  // reporting and bus tasks
  // ----------------------------
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic hang;
    bad_count++;
    $display("mismatch at %0t: bus did not answer", $time);
    complete_run;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      n++;
    end
    while (bvalid !== 1'b1 && n < 40);
    if (n >= 40)
      hang;
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      n++;
    end
    while (rvalid !== 1'b1 && n < 40);
    if (n >= 40)
      hang;
    v = rdata;
    r = rresp;
    rready <= 1'b0;
    chk(v, exp);
  endtask
  // ----------------------------
  // scenarios
  // ----------------------------
  task automatic s_enable;
    rchk(8'h00, 32'h0);
    rchk(8'h20, 32'h0);
    chk({30'h0, r}, 32'h2);
    wr(8'h24, 32'h1);
    chk({30'h0, r}, 32'h2);
    wr(8'h0c, 32'h0);
    wr(8'h10, 32'h0);
    wr(8'h18, 32'h1);
    wr(8'h00, 32'h28);
    i_asr_line_model.send(9'h05a, 1'b0, 1'b1);
    rchk(8'h14, 32'h0);
    wr(8'h00, 32'h2b);
    i_asr_line_model.send(9'h05a, 1'b0, 1'b1);
    rchk(8'h14, 32'h0);
    wr(8'h00, 32'h21);
    i_asr_line_model.send(9'h05a, 1'b0, 1'b1);
    rchk(8'h14, 32'h0);
  endtask
  task automatic s_eight;
    wr(8'h00, 32'h29);
    i_asr_line_model.send(9'h0a5, 1'b0, 1'b1);
    rchk(8'h14, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(8'h18, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(8'h18, 32'h1);
    rchk(8'h04, 32'h8);
    rchk(8'h08, 32'ha5);
    rchk(8'h04, 32'h0);
    wr(8'h1c, 32'h1);
    chk({31'h0, irq}, 32'h0);
  endtask
  task automatic s_nine;
    wr(8'h00, 32'h2d);
    i_asr_line_model.send(9'h1c3, 1'b1, 1'b1);
    rchk(8'h04, 32'h9);
    rchk(8'h08, 32'hc3);
    i_asr_line_model.send(9'h03c, 1'b1, 1'b1);
    rchk(8'h04, 32'h8);
    rchk(8'h08, 32'h3c);
    wr(8'h00, 32'h29);
    i_asr_line_model.send(9'h0f0, 1'b0, 1'b0);
    rchk(8'h14, 32'h3);
    rchk(8'h04, 32'ha);
    rchk(8'h08, 32'hf0);
    wr(8'h1c, 32'h7);
  endtask
  task automatic s_overrun;
    i_asr_line_model.send(9'h011, 1'b0, 1'b1);
    i_asr_line_model.send(9'h022, 1'b0, 1'b1);
    rchk(8'h04, 32'hc);
    rchk(8'h08, 32'h11);
    i_asr_line_model.send(9'h033, 1'b0, 1'b1);
    rchk(8'h04, 32'h4);
    rchk(8'h14, 32'h5);
    wr(8'h00, 32'h21);
    rchk(8'h04, 32'h0);
    wr(8'h1c, 32'h7);
  endtask
  task automatic s_addr;
    wr(8'h00, 32'h3d);
    i_asr_line_model.send(9'h055, 1'b1, 1'b1);
    rchk(8'h14, 32'h0);
    i_asr_line_model.send(9'h1aa, 1'b1, 1'b1);
    rchk(8'h14, 32'h1);
    rchk(8'h04, 32'h9);
    rchk(8'h08, 32'haa);
    wr(8'h1c, 32'h1);
    wr(8'h00, 32'h2d);
    i_asr_line_model.send(9'h033, 1'b1, 1'b1);
    rchk(8'h14, 32'h1);
    rchk(8'h08, 32'h33);
  endtask
  task automatic s_rate;
    wr(8'h10, 32'h1);
    wr(8'h0c, 32'h1);
    wr(8'h00, 32'h29);
    i_asr_line_model.bit_clks = 32;
    i_asr_line_model.send(9'h05a, 1'b0, 1'b1);
    rchk(8'h08, 32'h5a);
    wr(8'h0c, 32'h0);
    wr(8'h10, 32'h0);
    wr(8'h00, 32'h09);
    i_asr_line_model.bit_clks = 64;
    i_asr_line_model.send(9'h096, 1'b0, 1'b1);
    rchk(8'h08, 32'h96);
    i_asr_line_model.bit_clks = 16;
    wr(8'h1c, 32'h7);
  endtask
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    s_enable;
    s_eight;
    s_nine;
    s_overrun;
    s_addr;
    s_rate;
    complete_run;
  end
endmodule // test_asr_receiver
`default_nettype wire
